// ---- src/mpu_port_host.sv ----
// Host controller driving the device's chip enable, direction, command and data pins.
// Assumes a user request port on mclk_i and the device pins wired directly.
`timescale 1ns/1ps
`default_nettype none
`include "mpu_port_params.svh"

module mpu_port_host #(
  parameter int SETUP_CYC   = `MPU_CYC(`MPU_SETUP_NS),
  parameter int STROBE_CYC  = `MPU_CYC(`MPU_STROBE_NS),
  parameter int HOLD_CYC    = `MPU_CYC(`MPU_HOLD_NS),
  parameter int RECOVER_CYC = `MPU_CYC(`MPU_RECOVER_NS),
  parameter int RESET_CYC   = `MPU_CYC(`MPU_RESET_NS)
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    req_i,
  input  wire logic                    req_read_i,
  input  wire logic [`MPU_CMD_W-1:0]   req_cmd_i,
  input  wire logic [`MPU_DATA_W-1:0]  req_wdata_i,
  input  wire logic                    dev_reset_req_i,
  output logic                         req_ready_o,
  output logic                         rsp_valid_o,
  output logic [`MPU_DATA_W-1:0]       rsp_rdata_o,
  output logic                         dev_ce_n_o,
  output logic                         dev_rw_o,
  output logic [`MPU_CMD_W-1:0]        dev_cmd_o,
  output logic                         dev_reset_n_o,
  input  wire logic [`MPU_DATA_W-1:0]  dev_data_i,
  output logic [`MPU_DATA_W-1:0]       dev_data_o,
  output logic                         dev_data_oe_o
);

  // Counts must fit the down-counter; strobe covers the two-flop read path
  if (SETUP_CYC < 1 || SETUP_CYC > 255) begin : g_bad_setup
    $error("mpu_port_host: SETUP_CYC must be 1..255");
  end
  if (STROBE_CYC < 3 || STROBE_CYC > 255) begin : g_bad_strobe
    $error("mpu_port_host: STROBE_CYC must be 3..255");
  end
  if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_bad_hold
    $error("mpu_port_host: HOLD_CYC must be 1..255");
  end
  if (RECOVER_CYC < 1 || RECOVER_CYC > 255) begin : g_bad_recover
    $error("mpu_port_host: RECOVER_CYC must be 1..255");
  end
  if (RESET_CYC < 1 || RESET_CYC > 255) begin : g_bad_reset
    $error("mpu_port_host: RESET_CYC must be 1..255");
  end

  logic                    rst_s1_r;
  logic                    rst_s2_r;
  logic [`MPU_DATA_W-1:0]  din_s1_r;
  logic [`MPU_DATA_W-1:0]  din_s2_r;
  mpu_port_pkg::host_state_t state_r;
  mpu_port_pkg::host_state_t state_nxt;
  logic [`MPU_CNT_W-1:0]   cnt_r;
  logic [`MPU_CNT_W-1:0]   cnt_nxt;
  logic                    rd_r;
  logic [`MPU_DATA_W-1:0]  rdata_r;
  logic                    rsp_r;
  wire                     cnt_done;
  wire                     accept;
  wire                     rd_nxt;
  wire                     strobe_end;
  wire                     drive_nxt;

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Read data synchroniser
  always_ff @(posedge mclk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end else begin
      din_s1_r <= dev_data_i;
      din_s2_r <= din_s1_r;
    end
  end

  // Phases in which a write keeps the bus driven
  function automatic logic write_phase(input mpu_port_pkg::host_state_t s);
    logic hit;
    hit = (s == mpu_port_pkg::ST_SETUP) ||
          (s == mpu_port_pkg::ST_STROBE) ||
          (s == mpu_port_pkg::ST_HOLD);
    return hit;
  endfunction : write_phase

  assign cnt_done   = (cnt_r == 8'h00);
  assign accept     = (state_r == mpu_port_pkg::ST_IDLE) && req_i && !dev_reset_req_i;
  assign rd_nxt     = accept ? req_read_i : rd_r;
  assign strobe_end = (state_r == mpu_port_pkg::ST_STROBE) && cnt_done;
  assign drive_nxt  = !rd_nxt && write_phase(state_nxt);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_done ? cnt_r : cnt_r - 8'h01;
    case (state_r)
      mpu_port_pkg::ST_RESET: begin
        if (cnt_done) begin
          state_nxt = mpu_port_pkg::ST_IDLE;
        end
      end
      mpu_port_pkg::ST_IDLE: begin
        if (dev_reset_req_i) begin
          state_nxt = mpu_port_pkg::ST_RESET;
          cnt_nxt   = 8'(RESET_CYC - 1);
        end else if (req_i) begin
          state_nxt = mpu_port_pkg::ST_SETUP;
          cnt_nxt   = 8'(SETUP_CYC - 1);
        end
      end
      mpu_port_pkg::ST_SETUP: begin
        if (cnt_done) begin
          state_nxt = mpu_port_pkg::ST_STROBE;
          cnt_nxt   = 8'(STROBE_CYC - 1);
        end
      end
      mpu_port_pkg::ST_STROBE: begin
        if (cnt_done) begin
          state_nxt = mpu_port_pkg::ST_HOLD;
          cnt_nxt   = 8'(HOLD_CYC - 1);
        end
      end
      mpu_port_pkg::ST_HOLD: begin
        if (cnt_done) begin
          state_nxt = mpu_port_pkg::ST_RECOV;
          cnt_nxt   = 8'(RECOVER_CYC - 1);
        end
      end
      mpu_port_pkg::ST_RECOV: begin
        if (cnt_done) begin
          state_nxt = mpu_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = mpu_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r <= mpu_port_pkg::ST_RESET;
      cnt_r   <= 8'(RESET_CYC - 1);
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Request capture
  always_ff @(posedge mclk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      rd_r <= 1'b1;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // Read data taken just before enable rises
  always_ff @(posedge mclk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      rdata_r <= 8'h00;
      rsp_r   <= 1'b0;
    end else begin
      rsp_r <= strobe_end;
      if (strobe_end && rd_r) begin
        rdata_r <= din_s2_r;
      end
    end
  end

  // Chip enable low only in the strobe phase
  always_ff @(posedge mclk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      dev_ce_n_o <= 1'b1;
    end else begin
      dev_ce_n_o <= (state_nxt != mpu_port_pkg::ST_STROBE);
    end
  end

  // Direction, command and write data set when the request is taken
  always_ff @(posedge mclk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      dev_rw_o   <= 1'b1;
      dev_cmd_o  <= 3'h0;
      dev_data_o <= 8'h00;
    end else if (accept) begin
      dev_rw_o   <= req_read_i;
      dev_cmd_o  <= req_cmd_i;
      dev_data_o <= req_wdata_i;
    end
  end

  // Bus driven only through a write's setup, strobe and hold
  always_ff @(posedge mclk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      dev_data_oe_o <= 1'b0;
    end else begin
      dev_data_oe_o <= drive_nxt;
    end
  end

  // Device reset low while in the reset state
  always_ff @(posedge mclk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      dev_reset_n_o <= 1'b0;
    end else begin
      dev_reset_n_o <= (state_nxt != mpu_port_pkg::ST_RESET);
    end
  end

  assign req_ready_o = (state_r == mpu_port_pkg::ST_IDLE) && !dev_reset_req_i;
  assign rsp_valid_o = rsp_r;
  assign rsp_rdata_o = rdata_r;

endmodule : mpu_port_host
`default_nettype wire

// ---- src/mpu_port_params.svh ----
// Constants for the host-side controller of the parallel access port.
// Assumes inclusion by bare name from src/ files; definitions only.
//
// Contract
// - Access only while chip enable low
// - Write: chip enable and direction low
// - Read: chip enable low, direction high
// - Eight-bit bidirectional bus, bit zero least
`ifndef MPU_PORT_PARAMS_SVH
`define MPU_PORT_PARAMS_SVH

`define MPU_DATA_W      8
`define MPU_CMD_W       3
`define MPU_SETUP_NS    10
`define MPU_STROBE_NS   40
`define MPU_HOLD_NS     10
`define MPU_RECOVER_NS  20
`define MPU_RESET_NS    100
`define MPU_CLK_NS      5
`define MPU_CYC(ns)     (((ns) + `MPU_CLK_NS - 1) / `MPU_CLK_NS)
`define MPU_CNT_W       8

`endif

// ---- src/mpu_port_pkg.sv ----
// Types for the host-side controller of the parallel access port.
// Assumes nothing of its surroundings.
package mpu_port_pkg;
  typedef enum logic [2:0] {
    ST_RESET  = 3'h0,
    ST_IDLE   = 3'h1,
    ST_SETUP  = 3'h3,
    ST_STROBE = 3'h2,
    ST_HOLD   = 3'h6,
    ST_RECOV  = 3'h7
  } host_state_t;
endpackage : mpu_port_pkg

// ---- bench/mpu_port_host_properties.sv ----
// Pin checker for the host port controller.
// Assumes a bind onto mpu_port_host.
`timescale 1ns/1ps
`default_nettype none
module mpu_port_checker (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       dev_ce_n_o,
  input wire logic       dev_rw_o,
  input wire logic [2:0] dev_cmd_o,
  input wire logic [7:0] dev_data_o,
  input wire logic       dev_data_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence ce_held;
    !dev_ce_n_o ##1 !dev_ce_n_o;
  endsequence
  ctl_hold_a: assert property (ce_held |-> $stable(dev_rw_o) && $stable(dev_cmd_o))
    else $error("control moved in access");
  wr_drive_a: assert property (!dev_ce_n_o && !dev_rw_o |-> dev_data_oe_o)
    else $error("write without drive");
  rd_free_a: assert property (!dev_ce_n_o && dev_rw_o |-> !dev_data_oe_o)
    else $error("read with bus driven");
  wr_data_a: assert property (ce_held ##0 !dev_rw_o |-> $stable(dev_data_o))
    else $error("write data moved");
endmodule : mpu_port_checker
bind mpu_port_host mpu_port_checker i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .dev_ce_n_o(dev_ce_n_o), .dev_rw_o(dev_rw_o), .dev_cmd_o(dev_cmd_o),
  .dev_data_o(dev_data_o), .dev_data_oe_o(dev_data_oe_o));
`default_nettype wire

// ---- bench/mpu_dev_model.sv ----
// Device model of the parallel port.
// Assumes the host pins wired directly.
`timescale 1ns/1ps
`default_nettype none
module mpu_dev_model #(
  parameter int         DLY_NS = 0,
  parameter logic [7:0] LEGACY = 8'h00
) (
  input  wire logic       ce_n_i,
  input  wire logic       rw_i,
  input  wire logic [2:0] cmd_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] hd_i,
  input  wire logic       hoe_i,
  output logic [7:0]      bus_o
);
  logic [7:0] mem [8];
  logic       rw_r;
  logic [2:0] cmd_r;
  wire        rd_en;
  assign #(DLY_NS) rd_en = !ce_n_i && rw_r;
  always @(negedge ce_n_i) begin
    rw_r = rw_i;
    cmd_r = cmd_i;
  end
  always @(posedge ce_n_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 8; i++) mem[i] <= LEGACY;
    end else if (!rw_r) begin
      mem[cmd_r] <= bus_o;
    end
  end
  assign bus_o = hoe_i ? hd_i : rd_en ? mem[cmd_r] : ~mem[cmd_r];
endmodule : mpu_dev_model
`default_nettype wire

// ---- bench/mpu_parallel_access_port_test.sv ----
// Testbench for the host port controller.
// Assumes default timing parameters.
`timescale 1ns/1ps
`default_nettype none
module mpu_parallel_access_port_test;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, rd = 1'b0, drq = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic [7:0] wd = 8'h00, q;
  wire rdy, vld, ce_n, rw, rn, oe;
  wire [2:0] dc;
  wire [7:0] rq, dq, bus;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  mpu_port_host i_dut (.mclk_i(clk), .rst_n_i(rst_n), .req_i(req), .req_read_i(rd),
    .req_cmd_i(cmd), .req_wdata_i(wd), .dev_reset_req_i(drq), .req_ready_o(rdy),
    .rsp_valid_o(vld), .rsp_rdata_o(rq), .dev_ce_n_o(ce_n), .dev_rw_o(rw),
    .dev_cmd_o(dc), .dev_reset_n_o(rn), .dev_data_i(bus), .dev_data_o(dq),
    .dev_data_oe_o(oe));
  mpu_dev_model #(.DLY_NS(15), .LEGACY(8'h3C)) i_dev (.ce_n_i(ce_n), .rw_i(rw),
    .cmd_i(dc), .reset_n_i(rn), .hd_i(dq), .hoe_i(oe), .bus_o(bus));
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic idle();
    int n;
    n = 0;
    do @(posedge clk); while (rdy !== 1'b1 && ++n < 99);
  endtask : idle
  task automatic acc(input logic r, input logic [2:0] c, input logic [7:0] d);
    int n;
    idle();
    req <= 1'b1;
    rd <= r;
    cmd <= c;
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do @(posedge clk); while (vld !== 1'b1 && ++n < 99);
    chk({7'h00, vld}, 8'h01);
    @(posedge clk);
    q = rq;
  endtask : acc
  task automatic t_legacy();
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, c[2:0], 8'h00);
      chk(q, 8'h3C);
    end
  endtask : t_legacy
  task automatic t_wr_rd();
    for (int c = 0; c < 8; c++) acc(1'b0, c[2:0], 8'h81 ^ (8'h11 << c));
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, c[2:0], 8'h00);
      chk(q, 8'h81 ^ (8'h11 << c));
    end
  endtask : t_wr_rd
  task automatic t_dev_rst();
    idle();
    drq <= 1'b1;
    @(posedge clk);
    drq <= 1'b0;
    @(posedge clk);
    chk({7'h00, rn}, 8'h00);
    acc(1'b1, 3'h5, 8'h00);
    chk(q, 8'h3C);
  endtask : t_dev_rst
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_legacy();
    t_wr_rd();
    t_dev_rst();
    wrap_up();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      $display("Error %0t: timeout", $time);
      fail_count++;
      wrap_up();
    end
  end
endmodule : mpu_parallel_access_port_test
`default_nettype wire
